// File: logic/two_wire_pkg.sv
// Function
// - master only, sole clock source
// - lines only pulled low or released
// - wait until clock really seen high
// - data changes only while clock low
// - start: data falls, clock high
// - stop: data rises, clock high
// - bytes shifted most significant bit first
// - release data on ninth clock when writing; on reads, acknowledge unless final
// - address byte: type then pin bits
// - address bit zero selects direction
// - address acknowledge shows peripheral present
// - read: release data, clock bits in
// - standard rate, optional fourfold fast rate
// - contention shown by bus error flag
// - one data register for both directions
// - control status bit layout, reset zero
// - mode register: stop enable, fast
// - start bit: start before written byte
// - stop bit timing, accesses other than mode writes ignored meanwhile
// - done flag and request, cleared by access
// - contention cancels, disabled until stop
package two_wire_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int STD_RATE_KHZ = 100;
    localparam int FAST_MULT = 4;
    localparam int QTR_STD = CLK_HZ / (4 * STD_RATE_KHZ * 1000);
    localparam int QTR_FAST = CLK_HZ / (4 * STD_RATE_KHZ * 1000 * FAST_MULT);
    localparam logic [7:0] DIV_STD = 8'(QTR_STD - 1);
    localparam logic [7:0] DIV_FAST = 8'(QTR_FAST - 1);
    // register indices; byte address is four times the index
    localparam logic [29:0] IDX_CTRL_STATUS = 30'h0000e678;
    localparam logic [29:0] IDX_DATA_BYTE = 30'h0000e679;
    localparam logic [29:0] IDX_BUS_MODE = 30'h0000e67a;
    localparam logic [1:0] REG_NONE = 2'h0;
    localparam logic [1:0] REG_CS = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;
    localparam logic [1:0] REG_MODE = 2'h3;
    localparam int CS_START = 7;
    localparam int CS_STOP = 6;
    localparam int CS_FINAL_READ = 5;
    localparam int MODE_STOP_IRQ = 1;
    localparam int MODE_FAST = 0;
    localparam int ADDR_DIR_BIT = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [3:0] ACK_BIT = 4'h8;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_START = 6'h02,
        ST_BITS  = 6'h04,
        ST_HOLD  = 6'h08,
        ST_STOP  = 6'h10,
        ST_HALT  = 6'h20
    } ctl_state_t;
    typedef struct packed {
        ctl_state_t fsm;
        logic [1:0] phase;
        logic [3:0] bitCnt;
        logic [7:0] div;
        logic [7:0] shift;
        logic [7:0] dataByte;
        logic startBit, stopBit, finalReadFlag;
        logic busErrorFlag, ackFlag, doneFlag, irq;
        logic stopIrqEnable, fastRateSelect;
        logic readMode, readXfer;
        logic [1:0] bootId;
        logic sclMeta, sclSync, sdaMeta, sdaSync, sdaPrev;
        logic sclOe, sdaOe, pinLevel;
        logic apValid, apWrite;
        logic [1:0] apReg;
        logic [31:0] rdata;
        logic busReady, busResp;
    } ctl_regs_t;
endpackage

// File: logic/two_wire_bus_master.sv
`timescale 1ns/1ps
module two_wire_bus_master (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [1:0] bootId,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic irqReq
);
    import two_wire_pkg::*;

    ctl_regs_t s;
    ctl_regs_t next_s;
    logic apNow, locked, tick, adv, waitPh;
    logic [1:0] apSel;
    logic [7:0] qtr;
    logic rdAcc, wrAcc, dataAcc, anyAcc, wrCs, wrData, wrMode;
    logic setDone, setBerr, setIrq;

    localparam ctl_regs_t REGS_RST = '{
        fsm: ST_IDLE, phase: 2'h0, bitCnt: 4'h0, div: 8'h00,
        shift: 8'h00, dataByte: 8'h00, startBit: 1'b0, stopBit: 1'b0,
        finalReadFlag: 1'b0, busErrorFlag: 1'b0, ackFlag: 1'b0,
        doneFlag: 1'b0, irq: 1'b0, stopIrqEnable: MODE_RST[MODE_STOP_IRQ],
        fastRateSelect: MODE_RST[MODE_FAST], readMode: 1'b0, readXfer: 1'b0,
        bootId: 2'h0, sclMeta: 1'b1, sclSync: 1'b1, sdaMeta: 1'b1,
        sdaSync: 1'b1, sdaPrev: 1'b1, sclOe: 1'b0, sdaOe: 1'b0,
        pinLevel: 1'b0, apValid: 1'b0, apWrite: 1'b0, apReg: REG_NONE,
        rdata: 32'h00000000, busReady: 1'b1, busResp: 1'b0
    };

    // bus outputs and pins all come from the state register
    assign hreadyout = s.busReady;
    assign hrdata = s.rdata;
    assign hresp = s.busResp;
    assign sclOut = s.pinLevel;
    assign sdaOut = s.pinLevel;
    assign sclOe = s.sclOe;
    assign sdaOe = s.sdaOe;
    assign irqReq = s.irq;

    // address decode; only word accesses are expected from software
    always_comb begin
        if (haddr[31:2] == IDX_CTRL_STATUS) begin
            apSel = REG_CS;
        end else if (haddr[31:2] == IDX_DATA_BYTE) begin
            apSel = REG_DATA;
        end else if (haddr[31:2] == IDX_BUS_MODE) begin
            apSel = REG_MODE;
        end else begin
            apSel = REG_NONE;
        end
    end

    // whole next-state computation
    always_comb begin
        next_s = s;
        setDone = 1'b0;
        setBerr = 1'b0;
        setIrq = 1'b0;
        // two-stage synchronisers for the open-drain lines
        next_s.sclMeta = sclIn;
        next_s.sclSync = s.sclMeta;
        next_s.sdaMeta = sdaIn;
        next_s.sdaSync = s.sdaMeta;
        next_s.sdaPrev = s.sdaSync;
        next_s.bootId = bootId;
        next_s.pinLevel = 1'b0;
        next_s.busReady = 1'b1;
        next_s.busResp = 1'b0;

        // bus slave: side effects of reads act in the address phase
        apNow = hsel && hready && htrans[1];
        locked = (s.fsm == ST_STOP);
        next_s.apValid = apNow;
        next_s.apWrite = hwrite;
        next_s.apReg = apNow ? apSel : REG_NONE;
        if (apSel == REG_CS) begin
            next_s.rdata = {24'h000000, s.startBit, s.stopBit, s.finalReadFlag,
                s.bootId, s.busErrorFlag, s.ackFlag, s.doneFlag};
        end else if (apSel == REG_DATA) begin
            next_s.rdata = {24'h000000, s.dataByte};
        end else if (apSel == REG_MODE) begin
            next_s.rdata = {30'h00000000, s.stopIrqEnable, s.fastRateSelect};
        end else begin
            next_s.rdata = 32'h00000000;
        end
        rdAcc = apNow && !hwrite && !locked && (apSel == REG_CS || apSel == REG_DATA);
        wrAcc = s.apValid && s.apWrite && !locked;
        wrCs = wrAcc && (s.apReg == REG_CS);
        wrData = wrAcc && (s.apReg == REG_DATA);
        wrMode = s.apValid && s.apWrite && (s.apReg == REG_MODE);
        dataAcc = wrData || (rdAcc && apSel == REG_DATA);
        anyAcc = rdAcc || wrCs || wrData;

        // quarter-bit divider; fast select shortens the reload
        qtr = s.fastRateSelect ? DIV_FAST : DIV_STD;
        tick = (s.div == 8'h00);
        next_s.div = tick ? qtr : s.div - 8'h01;
        // the phase that releases the clock waits for the line itself
        waitPh = (s.fsm == ST_START && s.phase == 2'h1) ||
                 (s.fsm == ST_BITS && s.phase == 2'h2) ||
                 (s.fsm == ST_STOP && s.phase == 2'h2);
        if (waitPh && !s.sclSync) begin
            next_s.div = qtr;
        end
        adv = tick && (!waitPh || s.sclSync);

        case (s.fsm)
            ST_IDLE: begin
                next_s.sclOe = 1'b0;
                next_s.sdaOe = 1'b0;
                next_s.phase = 2'h0;
                if (s.stopBit) begin
                    next_s.fsm = ST_STOP;
                end else if (wrData && s.startBit) begin
                    next_s.fsm = ST_START;
                    next_s.shift = hwdata[7:0];
                    next_s.readMode = hwdata[ADDR_DIR_BIT];
                    next_s.readXfer = 1'b0;
                end
            end
            ST_HOLD: begin
                // bus owned: clock held low between bytes
                next_s.sclOe = 1'b1;
                next_s.sdaOe = 1'b0;
                next_s.phase = 2'h0;
                next_s.bitCnt = 4'h0;
                if (s.stopBit) begin
                    next_s.fsm = ST_STOP;
                end else if (wrData) begin
                    next_s.shift = hwdata[7:0];
                    next_s.readXfer = 1'b0;
                    if (s.startBit) begin
                        next_s.fsm = ST_START;
                        next_s.readMode = hwdata[ADDR_DIR_BIT];
                    end else begin
                        next_s.fsm = ST_BITS;
                    end
                end else if (rdAcc && apSel == REG_DATA && s.readMode) begin
                    next_s.fsm = ST_BITS;
                    next_s.readXfer = 1'b1;
                end
            end
            ST_START: begin
                if (adv) begin
                    next_s.phase = s.phase + 2'h1;
                    case (s.phase)
                        2'h0: begin
                            next_s.sdaOe = 1'b0;
                        end
                        2'h1: begin
                            next_s.sdaOe = 1'b1;
                        end
                        2'h2: begin
                            next_s.sclOe = 1'b0;
                        end
                        default: begin
                            next_s.sclOe = 1'b1;
                            next_s.fsm = ST_BITS;
                            next_s.bitCnt = 4'h0;
                        end
                    endcase
                end
                if (s.phase == 2'h1) begin
                    next_s.sclOe = 1'b0;
                end
            end
            ST_BITS: begin
                if (s.phase == 2'h2) begin
                    next_s.sclOe = 1'b0;
                end
                if (adv) begin
                    next_s.phase = s.phase + 2'h1;
                    if (s.phase == 2'h0) begin
                        // data moves here, well inside clock low, and is released again as the ninth clock falls
                        if (s.bitCnt == ACK_BIT) begin
                            next_s.sdaOe = s.readXfer && !s.finalReadFlag;
                        end else begin
                            next_s.sdaOe = !s.readXfer && !s.shift[7];
                        end
                    end else if (s.phase == 2'h3) begin
                        next_s.sclOe = 1'b1;
                        next_s.phase = 2'h0;
                        next_s.bitCnt = s.bitCnt + 4'h1;
                        if (s.bitCnt != ACK_BIT) begin
                            next_s.shift = {s.shift[6:0], s.readXfer ? s.sdaSync : 1'b0};
                            if (!s.readXfer && s.shift[7] && !s.sdaSync) begin
                                // someone else holds data low: give up the bus
                                setBerr = 1'b1;
                                next_s.fsm = ST_HALT;
                                next_s.sclOe = 1'b0;
                                next_s.sdaOe = 1'b0;
                            end
                        end else begin
                            setDone = 1'b1;
                            setIrq = 1'b1;
                            next_s.startBit = 1'b0;
                            next_s.sdaOe = 1'b0;
                            if (s.readXfer) begin
                                next_s.dataByte = s.shift;
                                next_s.finalReadFlag = 1'b0;
                            end else begin
                                next_s.ackFlag = !s.sdaSync;
                            end
                            next_s.fsm = s.stopBit ? ST_STOP : ST_HOLD;
                        end
                    end
                end
            end
            ST_STOP: begin
                if (s.phase == 2'h2) begin
                    next_s.sclOe = 1'b0;
                end
                if (adv) begin
                    next_s.phase = s.phase + 2'h1;
                    case (s.phase)
                        2'h0: begin
                            next_s.sclOe = 1'b1;
                        end
                        2'h1: begin
                            next_s.sdaOe = 1'b1;
                        end
                        2'h2: begin
                            next_s.sdaOe = 1'b0;
                        end
                        default: begin
                            next_s.fsm = ST_IDLE;
                            next_s.stopBit = 1'b0;
                            setIrq = s.stopIrqEnable;
                        end
                    endcase
                end
            end
            default: begin
                // disabled after contention until a stop appears on the bus
                next_s.sclOe = 1'b0;
                next_s.sdaOe = 1'b0;
                next_s.phase = 2'h0;
                if (s.sclSync && s.sdaSync && !s.sdaPrev) begin
                    next_s.fsm = ST_IDLE;
                end
            end
        endcase

        // software writes; hardware self-clears above lose to a new write
        if (wrCs) begin
            next_s.startBit = hwdata[CS_START];
            next_s.stopBit = hwdata[CS_STOP] || s.stopBit;
            next_s.finalReadFlag = hwdata[CS_FINAL_READ];
        end
        if (wrData) begin
            next_s.dataByte = hwdata[7:0];
        end
        if (wrMode) begin
            next_s.stopIrqEnable = hwdata[MODE_STOP_IRQ];
            next_s.fastRateSelect = hwdata[MODE_FAST];
        end
        // sticky flags: a set in the same cycle as a clear wins
        next_s.doneFlag = setDone || (s.doneFlag && !dataAcc);
        next_s.busErrorFlag = setBerr || (s.busErrorFlag && !dataAcc);
        next_s.irq = setIrq || (s.irq && !anyAcc);
    end

    // single state register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= REGS_RST;
        end else begin
            s <= next_s;
        end
    end

    chk_pins_open_drain:
    assert property (@(posedge mclk) disable iff (sys_rst) !sclOut && !sdaOut)
        else $error("line driven high");
    chk_idle_no_clock:
    assert property (@(posedge mclk) disable iff (sys_rst) (s.fsm == ST_IDLE) |-> !sclOe)
        else $error("clock pulled while idle");
    chk_stretch_wait:
    assert property (@(posedge mclk) disable iff (sys_rst)
        (s.fsm == ST_BITS && s.phase == 2'h2 && !s.sclSync) |=> (s.phase == 2'h2 && !sclOe))
        else $error("advanced while clock held low");
    chk_sda_steady_high:
    assert property (@(posedge mclk) disable iff (sys_rst)
        (s.fsm == ST_BITS && s.phase == 2'h3) |-> $stable(sdaOe))
        else $error("data moved while clock high");
    chk_start_shape:
    assert property (@(posedge mclk) disable iff (sys_rst)
        (s.fsm == ST_START && s.phase == 2'h3) |-> (sdaOe && !sclOe))
        else $error("bad start condition");
    chk_stop_shape:
    assert property (@(posedge mclk) disable iff (sys_rst)
        (s.fsm == ST_STOP && s.phase == 2'h3 && $changed(s.phase)) |-> (!sdaOe && !sclOe && $past(sdaOe)))
        else $error("bad stop condition");
    chk_msb_first:
    assert property (@(posedge mclk) disable iff (sys_rst)
        (s.fsm == ST_BITS && s.phase == 2'h1 && s.bitCnt < ACK_BIT && !s.readXfer)
        |-> (sdaOe == !s.shift[7]))
        else $error("wrong bit on data line");
    chk_ack_release:
    assert property (@(posedge mclk) disable iff (sys_rst)
        (s.fsm == ST_BITS && s.phase == 2'h1 && s.bitCnt == ACK_BIT && !s.readXfer) |-> !sdaOe)
        else $error("data held on ninth clock");
    chk_nine_clocks:
    assert property (@(posedge mclk) disable iff (sys_rst)
        (s.fsm == ST_BITS && s.phase == 2'h3 && tick && s.bitCnt == ACK_BIT)
        |=> (s.fsm == ST_HOLD || s.fsm == ST_STOP) && s.doneFlag)
        else $error("byte did not end after nine clocks");
    chk_done_clear:
    assert property (@(posedge mclk) disable iff (sys_rst) (dataAcc && !setDone) |=> !s.doneFlag)
        else $error("done not cleared by data access");
    chk_bus_error_flag_halt:
    assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(s.busErrorFlag) |-> (s.fsm == ST_HALT) ##1 (!sclOe && !sdaOe))
        else $error("contention did not release bus");
    chk_rate_reload:
    assert property (@(posedge mclk) disable iff (sys_rst)
        (tick && s.fastRateSelect) |=> (s.div == DIV_FAST))
        else $error("fast rate divider wrong");
endmodule

// File: test/serial_slave_model.sv
`timescale 1ns/1ps
module serial_slave_model #(
    parameter logic [6:0] DEV_ADDR = 7'h52
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] txByte,
    input wire logic [15:0] stretchNs,
    output logic sclPull,
    output logic sdaPull,
    output logic [7:0] rxLast,
    output logic masterAck,
    output int startCnt,
    output int stopCnt
);
    logic [3:0] cnt;
    logic [7:0] sh;
    logic addrPhase, selected, reading;
    initial begin
        sclPull = 1'b0; sdaPull = 1'b0; rxLast = 8'h00; masterAck = 1'b0;
        startCnt = 0; stopCnt = 0; cnt = 4'h0; sh = 8'h00;
        addrPhase = 1'b0; selected = 1'b0; reading = 1'b0;
    end
    // start and stop framing; the time guard skips the power-up edges of the lines
    always @(negedge sda) if (scl === 1'b1 && $realtime > 0) begin
        startCnt++; cnt = 4'h0; addrPhase = 1'b1; selected = 1'b0;
        reading = 1'b0; masterAck = 1'b0; sdaPull = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1 && $realtime > 0) begin
        stopCnt++; cnt = 4'h0; selected = 1'b0; sdaPull = 1'b0;
    end
    // sample on clock high, most significant bit first
    always @(posedge scl) begin
        if (cnt < 4'h8) sh = {sh[6:0], sda};
        if (cnt == 4'h8 && reading && !addrPhase) masterAck = sda;
        cnt++;
    end
    // a slow slave keeps the clock low after the master pulls it down
    always @(negedge scl) if (stretchNs != 16'h0) begin
        sclPull = 1'b1;
        #(stretchNs) sclPull = 1'b0;
    end
    // data moves only well inside the clock-low time, after a short hold
    always @(negedge scl) begin
        #50;
        if (cnt == 4'h8) begin
            if (addrPhase) begin
                selected = (sh[7:1] == DEV_ADDR);
                reading = sh[0];
            end else if (!reading) rxLast = sh;
            sdaPull = selected && (addrPhase || !reading);
        end else if (cnt == 4'h9) begin
            cnt = 4'h0;
            sdaPull = 1'b0;
            if (selected && reading && !masterAck) sdaPull = !txByte[7];
            addrPhase = 1'b0;
        end else if (cnt != 4'h0 && selected && reading && !addrPhase) begin
            sdaPull = !txByte[3'(7 - cnt)];
        end
    end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
    import two_wire_pkg::*;
    localparam logic [1:0] BOOT = 2'h2;
    localparam logic [6:0] SLV = 7'h52;
    localparam logic [31:0] A_CS = {IDX_CTRL_STATUS, 2'h0};
    localparam logic [31:0] A_DATA = {IDX_DATA_BYTE, 2'h0};
    localparam logic [31:0] A_MODE = {IDX_BUS_MODE, 2'h0};
    localparam logic [31:0] A_NONE = 32'h00039a00;
    localparam logic [31:0] ST_OK = {24'h0, 3'h0, BOOT, 3'h3};
    localparam int LIMIT = 90000;
    logic mclk, sysRst, hsel, hwrite, hreadyout, hresp, jam;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic sclOut, sclOe, sdaOut, sdaOe, irqReq, sclPull, sdaPull, sclLine, sdaLine, masterAck;
    logic [7:0] txByte, rxLast;
    logic [15:0] stretchNs;
    int startCnt, stopCnt, errors, nTests, cycles, s0;
    realtime lastRise, per;
    // open-drain lines: released means the pull-up wins
    assign sclLine = (sclOe ? sclOut : 1'b1) & ~sclPull;
    assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~sdaPull & ~jam;
    two_wire_bus_master dut_u (.mclk(mclk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .bootId(BOOT), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .irqReq(irqReq));
    serial_slave_model #(.DEV_ADDR(SLV)) slave_u (.scl(sclLine), .sda(sdaLine), .txByte(txByte),
        .stretchNs(stretchNs), .sclPull(sclPull), .sdaPull(sdaPull), .rxLast(rxLast), .masterAck(masterAck),
        .startCnt(startCnt), .stopCnt(stopCnt));
    always #12.5 mclk = ~mclk;
    // clock period seen on the line, latest pair of rising edges
    always @(posedge sclLine) begin
        per = $realtime - lastRise;
        lastRise = $realtime;
    end
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            results();
        end
    end
    task automatic results;
        $display("errors=%0d comparisons=%0d", errors, nTests);
        if (errors == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one single transfer; zero-wait slave, but the wait on ready stays open-ended
    task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] wd, output logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, wd};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        logic [31:0] d;
        bus(1'b1, a, v, d);
    endtask
    task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, a, 8'h00, d);
        `CHK(d, exp)
        `CHK({hreadyout, hresp}, 2'h2)
    endtask
    task automatic waitIrq;
        int k;
        k = 0;
        while (irqReq !== 1'b1 && k < 20000) begin
            @(posedge mclk);
            k++;
        end
        `CHK(irqReq, 1'b1)
    endtask
    // status polling only; a data access here would have side effects
    task automatic waitStop;
        logic [31:0] d;
        int k;
        d = 32'h40;
        k = 0;
        while (d[6] !== 1'b0 && k < 3000) begin
            bus(1'b0, A_CS, 8'h00, d);
            k++;
        end
        `CHK(d[6], 1'b0)
    endtask
    task automatic sendByte(input logic [7:0] v, input realtime lo, input realtime hi);
        wr(A_DATA, v);
        rdChk(A_CS, ST_OK & ~32'h1);
        waitIrq();
        rdChk(A_CS, ST_OK);
        `CHK(rxLast, v)
        `CHK(per >= lo && per <= hi, 1'b1)
    endtask
    task automatic addrByte(input logic [7:0] v, input logic [31:0] exp);
        wr(A_CS, 8'h80);
        wr(A_DATA, v);
        waitIrq();
        rdChk(A_CS, exp);
        repeat (2) @(posedge mclk);
        `CHK(irqReq, 1'b0)
    endtask
    // main sequence
    initial begin
        mclk = 1'b0; sysRst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; jam = 1'b0; txByte = 8'hb4; stretchNs = 16'h0;
        errors = 0; nTests = 0; cycles = 0; lastRise = 0; per = 0;
        repeat (4) @(posedge mclk);
        sysRst <= 1'b0;
        rdChk(A_CS, {27'h0, BOOT, 3'h0});
        rdChk(A_MODE, 32'h0);
        wr(A_MODE, 8'hff);
        rdChk(A_MODE, 32'h3);
        rdChk(A_NONE, 32'h0);
        // stop on an idle bus, stop request enabled
        wr(A_MODE, 8'h02);
        wr(A_CS, 8'h40);
        waitIrq();
        waitStop();
        `CHK(stopCnt, 1)
        wr(A_MODE, 8'h00);
        // write transfer at both rates and against a stretching slave
        s0 = startCnt;
        addrByte({SLV, 1'b0}, ST_OK);
        sendByte(8'ha6, 10000, 11000);
        wr(A_MODE, 8'h01);
        sendByte(8'h3c, 2500, 3000);
        wr(A_MODE, 8'h00);
        stretchNs <= 16'd8000;
        sendByte(8'h0f, 13000, 20000);
        stretchNs <= 16'h0;
        // accesses during the stop are ignored
        wr(A_CS, 8'h40);
        wr(A_DATA, 8'h81);
        wr(A_CS, 8'h80);
        waitStop();
        `CHK(stopCnt, 2)
        `CHK(startCnt, s0 + 1)
        rdChk(A_CS, ST_OK);
        // absent peripheral
        addrByte({7'h57, 1'b0}, ST_OK & ~32'h2);
        wr(A_CS, 8'h40);
        waitStop();
        // read transfer, last byte left unacknowledged
        addrByte({SLV, 1'b1}, ST_OK);
        bus(1'b0, A_DATA, 8'h00, rd);
        waitIrq();
        `CHK(masterAck, 1'b0)
        wr(A_CS, 8'h20);
        rdChk(A_CS, ST_OK | 32'h20);
        rdChk(A_DATA, 32'hb4);
        waitIrq();
        `CHK(masterAck, 1'b1)
        rdChk(A_CS, ST_OK);
        wr(A_CS, 8'h40);
        rdChk(A_DATA, 32'hb4);
        waitStop();
        // contention on a transmitted one, then recovery through a bus stop
        addrByte({SLV, 1'b0}, ST_OK);
        wr(A_DATA, 8'hff);
        @(posedge sclLine);
        @(posedge mclk) jam <= 1'b1;
        repeat (400) @(posedge mclk);
        bus(1'b0, A_CS, 8'h00, rd);
        `CHK(rd[2], 1'b1)
        `CHK({sclOe, sdaOe}, 2'h0)
        jam <= 1'b0;
        repeat (20) @(posedge mclk);
        bus(1'b0, A_DATA, 8'h00, rd);
        bus(1'b0, A_CS, 8'h00, rd);
        `CHK(rd[2], 1'b0)
        addrByte({SLV, 1'b0}, ST_OK);
        wr(A_CS, 8'h40);
        waitStop();
        results();
    end
endmodule
